// ### common/iod_pkg.sv
// iod_pkg: constants and carrier types for the i/o space access decoder
// assumes an 8-bit core bus and a peripheral fabric that answers in the same cycle
package iod_pkg;
   localparam int unsigned IOD_DATA_W      = 8;
   localparam int unsigned IOD_ADDR_W      = 9;
   localparam int unsigned IOD_IO_ADDR_W   = 6;
   localparam int unsigned IOD_BIT_W       = 3;
   localparam logic [8:0]  IOD_IO_OFFSET   = 9'h020;
   localparam logic [5:0]  IOD_BIT_IO_LAST = 6'h1F;
   localparam logic [5:0]  IOD_IO_LAST     = 6'h3F;
   localparam logic [8:0]  IOD_EXT_FIRST   = 9'h060;
   localparam logic [8:0]  IOD_EXT_LAST    = 9'h1FF;
   localparam logic [7:0]  IOD_ZERO_BYTE   = 8'h00;

   // nine operations need four bits
   typedef enum logic [3:0] {
      IOD_OP_NONE,
      IOD_OP_IN,
      IOD_OP_OUT,
      IOD_OP_BIT_SET,
      IOD_OP_BIT_CLEAR,
      IOD_OP_SKIP_ONE,
      IOD_OP_SKIP_ZERO,
      IOD_OP_DATA_LOAD,
      IOD_OP_DATA_STORE
   } iod_op_t;

   // core request: io ops use io_addr, load/store use data_addr
   typedef struct packed {
      logic        valid;
      iod_op_t     op;
      logic [5:0]  io_addr;
      logic [8:0]  data_addr;
      logic [2:0]  bit_sel;
      logic [7:0]  wdata;
   } iod_req_t;

   // answer to the core
   typedef struct packed {
      logic        done;
      logic        error;
      logic        skip;
      logic [7:0]  rdata;
   } iod_rsp_t;

   // peripheral side: one register port in data-space addressing
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [8:0]  addr;
      logic [7:0]  wdata;
   } iod_per_t;
endpackage : iod_pkg

// ### rtl/iod_decoder.sv
// iod_decoder: maps core i/o, bit and load/store accesses onto the peripheral register port
// assumes peripheral read data is combinational on per_rdata for the current request address
//
// What the document requires
// [R01] bit set and clear allowed only on i/o addresses 0x00 to 0x1f
// [R02] bit test skips next instruction when selected bit is one or zero
// [R03] write-one-to-clear flags clear on one, zero leaves them unchanged
// [R04] bit set/clear is read-modify-write of the whole register
// [R05] in/out ops address i/o locations 0 to 63
// [R06] load/store data address equals i/o address plus 0x20
// [R07] in/out opcode field encodes exactly 64 locations; more live in extended region
// [R08] extended region 0x60..0x1ff reachable only by load and store
// [R09] software should write zero to reserved bits
// [R10] software never writes reserved i/o addresses
// [R11] reserved locations read zero and cause no side effect
`timescale 1ns/1ps
module iod_decoder
   import iod_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire iod_req_t req,
   input  wire logic [7:0] per_rdata,
   input  wire logic     per_hit,
   output iod_rsp_t      rsp,
   output iod_per_t      per
);
   typedef enum logic [1:0] {IOD_IDLE, IOD_RMW_WRITE} iod_state_t;

   typedef struct packed {
      iod_state_t  state;
      iod_rsp_t    rsp;
      iod_per_t    per;
   } iod_st_t;

   iod_st_t st_reg;
   iod_st_t st_next;
   logic [8:0] io_as_data;
   logic [7:0] rd_val;
   logic [7:0] bit_mask;
   logic       io_op;

   // i/o number mapped into data space; 6-bit field bounds in/out to 64 places
   assign io_as_data = {3'b000, req.io_addr} + IOD_IO_OFFSET; // R06 R05 R07
   assign rd_val     = per_hit ? per_rdata : IOD_ZERO_BYTE; // R11
   assign bit_mask   = 8'h01 << req.bit_sel;
   assign io_op      = req.op inside {IOD_OP_IN, IOD_OP_OUT, IOD_OP_BIT_SET,
                                      IOD_OP_BIT_CLEAR, IOD_OP_SKIP_ONE, IOD_OP_SKIP_ZERO};

   always_comb begin
      st_next = st_reg;
      st_next.rsp = '0;
      st_next.per = '0;
      case (st_reg.state)
         IOD_IDLE: begin
            if (req.valid) begin
               case (req.op)
                  IOD_OP_IN: begin
                     st_next.rsp.done  = 1'b1;
                     st_next.rsp.rdata = rd_val; // R05
                     st_next.per.rd    = 1'b1;
                     st_next.per.addr  = io_as_data;
                  end
                  IOD_OP_OUT: begin
                     st_next.rsp.done  = 1'b1;
                     st_next.per.wr    = per_hit; // R11
                     st_next.per.addr  = io_as_data;
                     st_next.per.wdata = req.wdata;
                  end
                  IOD_OP_BIT_SET, IOD_OP_BIT_CLEAR: begin
                     if (req.io_addr > IOD_BIT_IO_LAST) begin
                        st_next.rsp.done  = 1'b1; // R01
                        st_next.rsp.error = 1'b1;
                     end else begin
                        // whole byte is written back, so flags read as one get cleared
                        st_next.state     = IOD_RMW_WRITE; // R04 R03
                        st_next.per.wr    = per_hit;
                        st_next.per.addr  = io_as_data;
                        st_next.per.wdata = (req.op == IOD_OP_BIT_SET) ?
                                            (rd_val | bit_mask) : (rd_val & ~bit_mask); // R04
                     end
                  end
                  IOD_OP_SKIP_ONE, IOD_OP_SKIP_ZERO: begin
                     st_next.rsp.done = 1'b1;
                     if (req.io_addr > IOD_BIT_IO_LAST) begin
                        st_next.rsp.error = 1'b1; // R01
                     end else begin
                        st_next.per.rd   = 1'b1;
                        st_next.per.addr = io_as_data;
                        st_next.rsp.skip = (req.op == IOD_OP_SKIP_ONE) ?
                                           |(rd_val & bit_mask) : ~|(rd_val & bit_mask); // R02
                     end
                  end
                  IOD_OP_DATA_LOAD: begin
                     st_next.rsp.done  = 1'b1;
                     st_next.rsp.rdata = rd_val; // R08 R11
                     st_next.per.rd    = 1'b1;
                     st_next.per.addr  = req.data_addr;
                  end
                  IOD_OP_DATA_STORE: begin
                     st_next.rsp.done  = 1'b1;
                     st_next.per.wr    = per_hit; // R08 R11
                     st_next.per.addr  = req.data_addr;
                     st_next.per.wdata = req.wdata;
                  end
                  default: begin
                  end
               endcase
            end
         end
         IOD_RMW_WRITE: begin
            st_next.state    = IOD_IDLE;
            st_next.rsp.done = 1'b1;
         end
         default: st_next.state = IOD_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '{state: IOD_IDLE, rsp: '0, per: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rsp = st_reg.rsp;
   assign per = st_reg.per;

   a_bit_range_err: assert property (@(posedge clk) disable iff (!rst_n) // R01
      (req.valid && st_reg.state == IOD_IDLE && io_op && req.op != IOD_OP_IN &&
       req.op != IOD_OP_OUT && req.io_addr > IOD_BIT_IO_LAST)
      |=> rsp.error && !per.wr)
      else $error("bit op above 0x1f not refused");
   a_skip_value: assert property (@(posedge clk) disable iff (!rst_n) // R02
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_SKIP_ONE &&
       req.io_addr <= IOD_BIT_IO_LAST && per_hit)
      |=> rsp.skip == $past(per_rdata[req.bit_sel]))
      else $error("skip result wrong");
   a_rmw_clear: assert property (@(posedge clk) disable iff (!rst_n) // R04
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_BIT_CLEAR &&
       req.io_addr <= IOD_BIT_IO_LAST && per_hit)
      |=> per.wr && per.wdata == ($past(per_rdata) & ~$past(bit_mask)) ##1 rsp.done)
      else $error("bit clear write-back wrong");
   a_rmw_set: assert property (@(posedge clk) disable iff (!rst_n) // R03
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_BIT_SET &&
       req.io_addr <= IOD_BIT_IO_LAST && per_hit)
      |=> per.wdata == ($past(per_rdata) | $past(bit_mask)))
      else $error("bit set write-back wrong");
   a_io_offset: assert property (@(posedge clk) disable iff (!rst_n) // R06
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_IN)
      |=> per.rd && per.addr == $past(req.io_addr) + IOD_IO_OFFSET)
      else $error("io address not offset by 0x20");
   a_io_range: assert property (@(posedge clk) disable iff (!rst_n) // R05
      (st_reg.state == IOD_IDLE && req.valid && req.op == IOD_OP_OUT)
      |=> per.addr <= ({3'b000, IOD_IO_LAST} + IOD_IO_OFFSET))
      else $error("io access left io window");
   a_ext_store: assert property (@(posedge clk) disable iff (!rst_n) // R08
      (st_reg.state == IOD_IDLE && req.valid && req.op == IOD_OP_DATA_STORE && per_hit)
      |=> per.wr && per.addr == $past(req.data_addr))
      else $error("store not passed through");
   a_reserved_quiet: assert property (@(posedge clk) disable iff (!rst_n) // R11
      (st_reg.state == IOD_IDLE && req.valid && !per_hit && req.op == IOD_OP_DATA_LOAD)
      |=> !per.wr && rsp.rdata == IOD_ZERO_BYTE)
      else $error("reserved access not quiet");

   // a bit set or clear on 0x00 to 0x1f owns the port for two cycles; the write-back is the first, done comes in the second
   a_rmw_wait: assert property (@(posedge clk) disable iff (!rst_n) // R04
      (req.valid && st_reg.state == IOD_IDLE &&
       req.op inside {IOD_OP_BIT_SET, IOD_OP_BIT_CLEAR} &&
       req.io_addr <= IOD_BIT_IO_LAST)
      |=> !rsp.done ##1 rsp.done && !per.wr && !per.rd)
      else $error("bit op write-back timing wrong");

   // requests in the write-back cycle are dropped, not queued
   a_rmw_ignore: assert property (@(posedge clk) disable iff (!rst_n) // R04
      (st_reg.state == IOD_RMW_WRITE)
      |=> rsp.done && !per.wr && !per.rd)
      else $error("request taken during write-back");

   a_skip_zero: assert property (@(posedge clk) disable iff (!rst_n) // R02
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_SKIP_ZERO &&
       req.io_addr <= IOD_BIT_IO_LAST && per_hit)
      |=> rsp.done && rsp.skip == !$past(per_rdata[req.bit_sel]))
      else $error("skip on zero result wrong");

   a_refused_quiet: assert property (@(posedge clk) disable iff (!rst_n) // R01
      (req.valid && st_reg.state == IOD_IDLE &&
       req.op inside {IOD_OP_BIT_SET, IOD_OP_BIT_CLEAR, IOD_OP_SKIP_ONE, IOD_OP_SKIP_ZERO} &&
       req.io_addr > IOD_BIT_IO_LAST)
      |=> rsp.done && !per.rd && !rsp.skip)
      else $error("refused bit op touched the port");

   // reads pass straight through; reserved ones were zeroed in rd_val
   a_in_data: assert property (@(posedge clk) disable iff (!rst_n) // R05
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_IN && per_hit)
      |=> rsp.done && rsp.rdata == $past(per_rdata))
      else $error("in data wrong");

   // the six-bit field keeps every in access inside the 64-place window
   a_in_window: assert property (@(posedge clk) disable iff (!rst_n) // R07
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_IN)
      |=> per.addr >= IOD_IO_OFFSET && per.addr <= ({3'b000, IOD_IO_LAST} + IOD_IO_OFFSET))
      else $error("in access left io window");

   // extended registers sit above the io window; only load and store land there
   a_io_no_ext: assert property (@(posedge clk) disable iff (!rst_n) // R08
      (req.valid && st_reg.state == IOD_IDLE && io_op)
      |=> per.addr < IOD_EXT_FIRST)
      else $error("io op reached extended region");

   a_ext_load: assert property (@(posedge clk) disable iff (!rst_n) // R08
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_DATA_LOAD &&
       req.data_addr >= IOD_EXT_FIRST && req.data_addr <= IOD_EXT_LAST)
      |=> per.rd && rsp.done && per.addr == $past(req.data_addr))
      else $error("extended load not passed through");

   // zero bits pass as zero, so a write-one-to-clear flag written zero is left alone
   a_out_data: assert property (@(posedge clk) disable iff (!rst_n) // R03
      (req.valid && st_reg.state == IOD_IDLE && req.op == IOD_OP_OUT && per_hit)
      |=> per.wr && per.wdata == $past(req.wdata))
      else $error("out data not passed through");
endmodule : iod_decoder

// ### test/iod_per_model.sv
// iod_per_model: behavioural peripheral register file behind the decoder
// assumes read data follows the current request address with no delay
`timescale 1ns/1ps
module iod_per_model
   import iod_pkg::*;
(
   input  wire logic     clk,
   input  wire iod_req_t req,
   input  wire iod_per_t per,
   output logic [7:0]    per_rdata,
   output logic          per_hit,
   output int            bad_wr
);
   logic [7:0] mem [0:511];
   logic [8:0] a;
   int         bad_cnt = 0;
   function automatic logic hitf(logic [8:0] x);
      return !(x inside {9'h020, 9'h021, 9'h022, 9'h05C, 9'h063, 9'h1FF});
   endfunction : hitf
   initial begin
      for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5A;
      mem[9'h036] = 8'hFF;
   end
   assign a = (req.op inside {IOD_OP_DATA_LOAD, IOD_OP_DATA_STORE}) ? req.data_addr
              : {3'b000, req.io_addr} + IOD_IO_OFFSET;
   assign per_hit   = hitf(a);
   assign bad_wr    = bad_cnt;
   // no register here: floating bus, so never a harmless zero
   assign per_rdata = per_hit ? mem[a] : ~mem[a];
   always @(posedge clk) begin
      if (per.wr && !hitf(per.addr)) bad_cnt++;
      else if (per.wr && per.addr == 9'h036) mem[per.addr] <= mem[per.addr] & ~per.wdata;
      else if (per.wr) mem[per.addr] <= per.wdata;
   end
endmodule : iod_per_model

// ### test/tb_top.sv
// tb_top: self-checking bench for the i/o space access decoder
// assumes the peripheral model answers reads in the request cycle
`timescale 1ns/1ps
module tb_top
   import iod_pkg::*;
;
   logic       clk = 0;
   logic       rst_n = 0;
   iod_req_t   req;
   iod_rsp_t   rsp;
   iod_rsp_t   got;
   iod_per_t   per;
   logic [7:0] per_rdata;
   logic       per_hit;
   int         bad_wr;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         cyc = 0;
   int         rf [0:511];
   always #4 clk = ~clk;
   iod_decoder uut (.clk(clk), .rst_n(rst_n), .req(req), .per_rdata(per_rdata),
                    .per_hit(per_hit), .rsp(rsp), .per(per));
   iod_per_model peer (.clk(clk), .req(req), .per(per), .per_rdata(per_rdata),
                       .per_hit(per_hit), .bad_wr(bad_wr));
   function automatic bit hit(int x);
      return !(x inside {32, 33, 34, 92, 99, 511});
   endfunction : hit
   function automatic void wr(int a, int d);
      if (hit(a)) rf[a] = (a == 54) ? (rf[a] & ~d & 255) : (d & 255);
   endfunction : wr
   task automatic chk(string nm, int e, logic [8:0] g);
      n_checks++;
      if (g !== e[8:0]) begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic chk_per(string nm, int e, logic [8:0] g);
      n_checks++;
      if (g !== e[8:0]) begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk_per
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task automatic op(iod_op_t o, int a, int b, int d);
      int da, v, n, er, sk, rd, prd, pwr;
      da = (o inside {IOD_OP_DATA_LOAD, IOD_OP_DATA_STORE}) ? a : a + 32;
      er = (o inside {IOD_OP_BIT_SET, IOD_OP_BIT_CLEAR, IOD_OP_SKIP_ONE, IOD_OP_SKIP_ZERO}) && a > 31;
      prd = !er && (o inside {IOD_OP_IN, IOD_OP_DATA_LOAD, IOD_OP_SKIP_ONE, IOD_OP_SKIP_ZERO});
      pwr = (o inside {IOD_OP_OUT, IOD_OP_DATA_STORE}) && hit(da);
      v = hit(da) ? rf[da] : 0;
      rd = 0;
      sk = 0;
      if (!er) case (o)
         IOD_OP_IN, IOD_OP_DATA_LOAD: rd = v;
         IOD_OP_SKIP_ONE: sk = (v >> b) & 1;
         IOD_OP_SKIP_ZERO: sk = !((v >> b) & 1);
         IOD_OP_OUT, IOD_OP_DATA_STORE: wr(da, d);
         IOD_OP_BIT_SET: wr(da, v | (1 << b));
         IOD_OP_BIT_CLEAR: wr(da, v & ~(1 << b));
         default: ;
      endcase
      req = '{1'b1, o, a[5:0], a[8:0], b[2:0], d[7:0]};
      @(posedge clk);
      #1 req.valid = 0;
      n = 0;
      while (rsp.done !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1 n++;
      end
      got = rsp;
      chk("done", 1, got.done);
      chk("rdata", rd, got.rdata);
      chk("skip", sk, got.skip);
      chk("error", er, got.error);
      chk_per("per rd", prd, per.rd);
      chk_per("per wr", pwr, per.wr);
      if (prd || pwr) chk_per("per addr", da, per.addr);
      @(posedge clk);
      #1;
   endtask : op
   always @(posedge clk) begin
      cyc++;
      if (cyc > 6000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      int a;
      req = '0;
      for (int i = 0; i < 512; i++) rf[i] = (i & 255) ^ 'h5A;
      rf[54] = 255;
      a = $urandom(48101);
      repeat (6) @(posedge clk);
      #1 rst_n = 1;
      for (int i = 0; i < 64; i++) op(IOD_OP_IN, i, 0, 0);
      op(IOD_OP_OUT, 22, 0, 0);
      op(IOD_OP_OUT, 22, 0, 'h0F);
      op(IOD_OP_IN, 22, 0, 0);
      op(IOD_OP_OUT, 22, 0, 'h2F);
      op(IOD_OP_IN, 22, 0, 0);
      for (int i = 0; i < 24; i++) begin
         do a = $urandom % 64; while (!hit(a + 32));
         op(IOD_OP_OUT, a, 0, $urandom % 256);
         op(IOD_OP_IN, a, 0, 0);
      end
      $display("test in/out done");
      for (int i = 0; i < 64; i++) begin
         if (hit(i + 32)) op(IOD_OP_BIT_SET, i, $urandom % 8, 0);
         op(IOD_OP_SKIP_ONE, i, $urandom % 8, 0);
         if (hit(i + 32)) op(IOD_OP_BIT_CLEAR, i, $urandom % 8, 0);
         op(IOD_OP_SKIP_ZERO, i, $urandom % 8, 0);
         op(IOD_OP_IN, i, 0, 0);
      end
      $display("test bit ops done");
      for (int i = 0; i < 32; i++) begin
         do a = 96 + $urandom % 416; while (!hit(a));
         op(IOD_OP_DATA_STORE, a, 0, $urandom % 256);
         op(IOD_OP_DATA_LOAD, a, 0, 0);
      end
      op(IOD_OP_DATA_LOAD, 54, 0, 0);
      op(IOD_OP_DATA_LOAD, 99, 0, 0);
      op(IOD_OP_DATA_LOAD, 511, 0, 0);
      $display("test load/store done");
      chk("reserved writes", 0, bad_wr[8:0]);
      end_sim();
   end
endmodule : tb_top
